// [common/flash_regs_map.svh]
// Register map constants for the divider and lock registers.
// Assumes inclusion by bare name; definitions only.
`ifndef FLASH_REGS_MAP_SVH
`define FLASH_REGS_MAP_SVH

// Register byte addresses on the APB bus
`define DIVIDER_ADDR       12'h000
`define LOCK_CONFIG_ADDR   12'h004
`define CONTROL_ADDR       12'h008
`define STATUS_ADDR        12'h00C
// Divider register fields
`define LOADED_BIT         7
`define LOCK_BIT           6
`define DIVIDER_MSB        5
`define DIVIDER_RESET      8'h00
// Lock config fields
`define KEY_ENABLE_MSB     7
`define KEY_ENABLE_LSB     6
`define LOCK_STATE_MSB     1
`define LOCK_STATE_LSB     0
`define LOCK_CONFIG_RESET  8'hFF
`define FIELD_OPEN         2'h2
// Control and status bits
`define CTRL_UNLOCK_BIT    0
`define STAT_LOADING_BIT   0
`define STAT_KEY_EN_BIT    1
`define STAT_OPEN_BIT      2
`define STAT_TICK_BIT      3
`define STAT_CMD_DONE_BIT  4
// Timebase target
`define TIMEBASE_MHZ       1
`define NV_PHRASE_ADDR     24'hFF_FE0F

`endif

// [common/flash_regs_pkg.sv]
// Types shared by the divider and lock register bank.
// Assumes the map header provides numeric constants.
package flash_regs_pkg;
	typedef enum logic [1:0] {
		load_idle,
		load_request,
		load_wait,
		load_done
	} load_state_type;

	typedef logic [7:0] reg_byte_type;
endpackage

// [common/nv_load_if.sv]
// Handshake carrying the nonvolatile configuration byte at reset.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface nv_load_if;
	logic       start;
	logic       done;
	logic       fault;
	logic [7:0] data;
	modport loader (input start, output done, output fault, output data);
	modport owner  (output start, input done, input fault, input data);
endinterface

// [src/flash_divider_lock_regs.sv]
// Divider and lock-config register bank with APB slave.
// Assumes APB master on pclk; flash read port serves the config byte.
//
// Operation
// - All divider bits readable; writes to load flag bit 7 ignored.
// - Normal mode: lock bit write-once-high freezes the divider field.
// - Special mode: bits 6..0 rewritable any time once config is loaded; bit 7 never.
// - Load flag clears at reset, sets on any divider write with pstrb[0] high once config is loaded.
// - Only reset or a special-mode write clears the lock bit and restores field writability.
// - Divider field scales bus clock to a 1 MHz timebase.
// - Lock config register readable; all writes ignored.
// - Lock config loaded from nonvolatile byte during reset sequence.
// - Double-bit fault on that read sets every lock config bit.
// - Key enable field 10 enables backdoor; others disable it.
// - Lock state field 10 means unlocked; others mean locked.
// - Backdoor unlock forces lock state field to read 10.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "flash_regs_map.svh"
module flash_divider_lock_regs
	import flash_regs_pkg::*;
#(
	parameter int DIV_WIDTH = 6
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Mode and flash status
	input  wire logic        special_mode,
	input  wire logic        command_complete_flag,
	input  wire logic        backdoor_unlock,
	// Flash read port for the configuration byte
	output logic             nv_read_req,
	output logic      [23:0] nv_read_addr,
	input  wire logic        nv_read_valid,
	input  wire logic        nv_read_fault,
	input  wire logic [7:0]  nv_read_data,
	// Timebase and decoded state
	output logic             timebase_tick,
	output logic             backdoor_enabled,
	output logic             device_unlocked,
	output logic             config_loaded
);
	nv_load_if load ();

	reg_byte_type   prog_clock_divider;
	reg_byte_type   device_lock_config;
	load_state_type load_state;
	load_state_type next_load_state;
	logic           forced_open;
	logic           tick_raw;
	logic           tick_seen;
	logic           nv_req_int;
	logic [23:0]    nv_addr_int;

	// Field decode shared by status and outputs
	function automatic logic field_is_open(input logic [1:0] f);
		return f == `FIELD_OPEN;
	endfunction

	// APB decode
	wire access     = psel & penable;
	wire wr_access  = access & pwrite & pstrb[0];
	wire hit_div    = paddr == `DIVIDER_ADDR;
	wire hit_lock   = paddr == `LOCK_CONFIG_ADDR;
	wire hit_ctrl   = paddr == `CONTROL_ADDR;
	wire hit_stat   = paddr == `STATUS_ADDR;
	wire mapped     = hit_div | hit_lock | hit_ctrl | hit_stat;
	wire div_write  = wr_access & hit_div & config_loaded;
	wire lock_set   = prog_clock_divider[`LOCK_BIT];
	wire field_free = special_mode | ~lock_set;

	// Lock config field views
	wire [1:0] key_field  =
		device_lock_config[`KEY_ENABLE_MSB:`KEY_ENABLE_LSB];
	wire [1:0] lock_field = forced_open ? `FIELD_OPEN :
		device_lock_config[`LOCK_STATE_MSB:`LOCK_STATE_LSB];
	wire       key_on     = field_is_open(key_field);
	wire       open_now   = field_is_open(lock_field);
	wire [7:0] lock_view  = {device_lock_config[7:2], lock_field};

	// Status word
	wire [7:0] status_view = {3'h0,
		command_complete_flag, tick_seen, open_now, key_on,
		~config_loaded};

	// Read mux; every bit of each register readable
	wire [7:0] read_byte =
		hit_div  ? prog_clock_divider :
		hit_lock ? lock_view :
		hit_ctrl ? {7'h00, forced_open} :
		hit_stat ? status_view : 8'h00;

	// Divider register next value
	wire [7:0] next_divider = {
		1'b1,
		special_mode ? pwdata[`LOCK_BIT] :
			(lock_set | pwdata[`LOCK_BIT]),
		field_free ? pwdata[`DIVIDER_MSB:0] :
			prog_clock_divider[`DIVIDER_MSB:0]
	};

	// Loader handshake
	assign load.start = (load_state == load_request) ||
		(load_state == load_wait);

	nv_byte_loader loader (
		.pclk          (pclk),
		.presetn       (presetn),
		.nv_read_req   (nv_req_int),
		.nv_read_addr  (nv_addr_int),
		.nv_read_valid (nv_read_valid),
		.nv_read_fault (nv_read_fault),
		.nv_read_data  (nv_read_data),
		.load          (load)
	);

	// Timebase from the divider field, runs once load flag bit 7 is set
	timebase_divider #(
		.WIDTH (DIV_WIDTH)
	) timebase (
		.pclk         (pclk),
		.presetn      (presetn),
		.enable       (prog_clock_divider[`LOADED_BIT]),
		.divide_value (prog_clock_divider[DIV_WIDTH-1:0]),
		.tick         (tick_raw)
	);

	// Reset-sequence load state machine
	always_comb begin
		next_load_state = load_state;
		case (load_state)
			load_idle:    next_load_state = load_request;
			load_request: next_load_state = load_wait;
			load_wait:
				if (load.done) begin
					next_load_state = load_done;
				end
			load_done:    next_load_state = load_done;
			default:      next_load_state = load_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_state <= load_idle;
		end else begin
			load_state <= next_load_state;
		end
	end

	// Divider register; bit 7 only set by hardware
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_clock_divider <= `DIVIDER_RESET;
		end else if (div_write) begin
			prog_clock_divider <= next_divider;
		end
	end

	// Lock config loaded once; software writes never reach it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			device_lock_config <= `LOCK_CONFIG_RESET;
		end else if (load_state == load_wait && load.done) begin
			device_lock_config <= load.fault ?
				`LOCK_CONFIG_RESET : load.data;
		end
	end

	// Backdoor unlock is sticky until reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			forced_open <= 1'b0;
		end else if (backdoor_unlock && key_on && config_loaded) begin
			forced_open <= 1'b1;
		end
	end

	// Tick seen flag; set wins over status read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_seen <= 1'b0;
		end else if (tick_raw) begin
			tick_seen <= 1'b1;
		end else if (access && !pwrite && hit_stat) begin
			tick_seen <= 1'b0;
		end
	end

	// APB answer registered; zero wait on setup, ready in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= (psel & ~penable & ~pwrite) ?
				{24'h00_0000, read_byte} : 32'h0000_0000;
		end
	end

	// Registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timebase_tick    <= 1'b0;
			backdoor_enabled <= 1'b0;
			device_unlocked  <= 1'b0;
			config_loaded    <= 1'b0;
			nv_read_req      <= 1'b0;
			nv_read_addr     <= 24'h00_0000;
		end else begin
			timebase_tick    <= tick_raw;
			backdoor_enabled <= key_on & config_loaded;
			device_unlocked  <= open_now & config_loaded;
			config_loaded    <= (load_state == load_done);
			nv_read_req      <= nv_req_int & ~load.done;
			nv_read_addr     <= nv_addr_int;
		end
	end
endmodule

// [src/nv_byte_loader.sv]
// Fetches the configuration byte from program flash after reset.
// Assumes a flash read port with valid pulse and double-fault flag.
`timescale 1ns/1ps
`include "flash_regs_map.svh"
module nv_byte_loader (
	// Clock and reset
	input  wire logic   pclk,
	input  wire logic   presetn,
	// Flash read port
	output logic        nv_read_req,
	output logic [23:0] nv_read_addr,
	input  wire logic   nv_read_valid,
	input  wire logic   nv_read_fault,
	input  wire logic [7:0] nv_read_data,
	// Handshake to owner
	nv_load_if.loader   load
);
	assign nv_read_addr = `NV_PHRASE_ADDR;
	assign nv_read_req  = load.start & ~load.done;

	// Capture byte and fault flag when the read returns
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load.done  <= 1'b0;
			load.fault <= 1'b0;
			load.data  <= 8'h00;
		end else if (nv_read_req && nv_read_valid) begin
			load.done  <= 1'b1;
			load.fault <= nv_read_fault;
			load.data  <= nv_read_data;
		end
	end
endmodule

// [src/timebase_divider.sv]
// Divides pclk to a nominal 1 MHz tick using the divider field.
// Assumes field value n gives a period of n+1 cycles.
`timescale 1ns/1ps
module timebase_divider #(
	parameter int WIDTH = 6
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Control
	input  wire logic             enable,
	input  wire logic [WIDTH-1:0] divide_value,
	// Tick
	output logic                  tick
);
	logic [WIDTH-1:0] count;
	wire              wrap = (count >= divide_value);

	// Count up to the field value then emit one tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (!enable) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			count <= wrap ? '0 : count + 1'b1;
			tick  <= wrap;
		end
	end
endmodule

// [test/flash_divider_lock_regs_assertions.sv]
// Port checker for the divider and lock register bank.
// Assumes one pclk domain and a zero-wait APB slave.
`timescale 1ns/1ps
module flash_divider_lock_regs_assertions (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Flash read and decoded state
	input wire logic        nv_read_req,
	input wire logic [23:0] nv_read_addr,
	input wire logic        nv_read_valid,
	input wire logic        nv_read_fault,
	input wire logic        backdoor_enabled,
	input wire logic        device_unlocked,
	input wire logic        config_loaded
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Read of the lock config register
	wire logic rd_cfg = pready && !pwrite && paddr == 12'h004;
	chk_ready_access: assert property (psel && penable |-> pready)
		else $error("no ready in access phase");
	chk_ready_phase: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	chk_err_unmapped: assert property (pready && paddr > 12'h00C |-> pslverr)
		else $error("unmapped access without error");
	chk_upper_zero: assert property (pready && !pwrite |-> !prdata[31:8])
		else $error("upper read bits not zero");
	chk_nv_addr: assert property (
		nv_read_req |-> nv_read_addr == 24'hFF_FE0F)
		else $error("wrong config byte address");
	chk_fault_locks: assert property (
		nv_read_req && nv_read_valid && nv_read_fault |-> ##4
		(config_loaded && !backdoor_enabled && !device_unlocked))
		else $error("fault did not lock");
	chk_key_decode: assert property (
		rd_cfg && config_loaded |->
		backdoor_enabled == (prdata[7:6] == 2'h2))
		else $error("key field decode wrong");
	chk_lock_decode: assert property (
		rd_cfg && config_loaded |->
		device_unlocked == (prdata[1:0] == 2'h2))
		else $error("lock field decode wrong");
	chk_loaded_holds: assert property (config_loaded |=> config_loaded)
		else $error("config loaded flag dropped");
endmodule

bind flash_divider_lock_regs flash_divider_lock_regs_assertions chk_i (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .nv_read_req, .nv_read_addr, .nv_read_valid, .nv_read_fault,
	.backdoor_enabled, .device_unlocked, .config_loaded);

// [test/testbench.sv]
// Self-checking bench for the divider and lock register bank.
// Assumes a zero-wait APB slave; the bench serves the config byte.
`timescale 1ns/1ps
`include "flash_regs_map.svh"
module testbench;
	// Bus side
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [3:0]  pstrb = 4'hF;
	logic        pready, pslverr, err;
	// Mode, flash port and state
	logic        special_mode = 0, command_complete_flag = 1;
	logic        backdoor_unlock = 0, nv_read_valid = 0, nv_read_fault = 0;
	logic        nv_read_req, timebase_tick, backdoor_enabled;
	logic        device_unlocked, config_loaded;
	logic [23:0] nv_read_addr;
	logic [7:0]  nv_read_data = 0;
	int          miscompares = 0, n_compared = 0, ticks;

	flash_divider_lock_regs flash_divider_lock_regs_i (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .special_mode, .command_complete_flag, .backdoor_unlock,
		.nv_read_req, .nv_read_addr, .nv_read_valid, .nv_read_fault,
		.nv_read_data, .timebase_tick, .backdoor_enabled, .device_unlocked,
		.config_loaded);

	// 100 MHz clock
	initial begin
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	// One APB transfer, setup then access until ready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk) penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) miscompares++;
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask

	// Reset, then serve the config byte
	task automatic boot(input logic [7:0] b, input logic f);
		int n;
		presetn <= 0;
		repeat (6) @(posedge pclk);
		presetn <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (nv_read_req !== 1'b1 && n < 20);
		if (n >= 20) miscompares++;
		chk(nv_read_addr, `NV_PHRASE_ADDR);
		nv_read_valid <= 1;
		nv_read_data <= b;
		nv_read_fault <= f;
		@(posedge pclk) nv_read_valid <= 0;
		repeat (4) @(posedge pclk);
		chk(config_loaded, 1);
	endtask

	task automatic t_config;
		for (int i = 0; i < 5; i++) begin
			boot({i[1:0], 4'hF, i[1:0]}, i == 4);
			apb(0, `LOCK_CONFIG_ADDR, 0);
			chk(r, i == 4 ? 8'hFF : {i[1:0], 4'hF, i[1:0]});
			chk(backdoor_enabled, i == 2);
			chk(device_unlocked, i == 2);
		end
		$display("t_config done");
	endtask

	task automatic t_backdoor;
		boot(8'hBD, 0);
		apb(1, `LOCK_CONFIG_ADDR, 8'h00);
		apb(0, `LOCK_CONFIG_ADDR, 0);
		chk(r, 8'hBD);
		backdoor_unlock <= 1;
		@(posedge pclk) backdoor_unlock <= 0;
		repeat (2) @(posedge pclk);
		chk(device_unlocked, 1);
		apb(0, `LOCK_CONFIG_ADDR, 0);
		chk(r, 8'hBE);
		apb(0, `STATUS_ADDR, 0);
		chk(r, 8'h16);
		apb(0, `CONTROL_ADDR, 0);
		chk(r, 8'h01);
		apb(0, 12'h010, 0);
		chk(err, 1);
		$display("t_backdoor done");
	endtask

	// Write then read back the divider
	task automatic wrd(input logic [7:0] d, input logic [7:0] exp);
		apb(1, `DIVIDER_ADDR, d);
		apb(0, `DIVIDER_ADDR, 0);
		chk(r, exp);
		chk(err, 0);
	endtask

	task automatic t_divider;
		boot(8'hBD, 0);
		apb(0, `DIVIDER_ADDR, 0);
		chk(r, 8'h00);
		wrd(8'h05, 8'h85);
		ticks = 0;
		repeat (60) begin
			@(posedge pclk);
			ticks += timebase_tick;
		end
		chk(ticks, 10);
		apb(0, `STATUS_ADDR, 0);
		chk(r, 8'h1A);
		pstrb <= 4'hE;
		wrd(8'h3F, 8'h85);
		pstrb <= 4'hF;
		wrd(8'h45, 8'hC5);
		wrd(8'h0A, 8'hC5);
		boot(8'hBD, 0);
		apb(0, `DIVIDER_ADDR, 0);
		chk(r, 8'h00);
		wrd(8'h0A, 8'h8A);
		special_mode <= 1;
		wrd(8'h47, 8'hC7);
		wrd(8'h31, 8'hB1);
		wrd(8'h05, 8'h85);
		special_mode <= 0;
		$display("t_divider done");
	endtask

	task automatic complete_run;
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		t_config();
		t_backdoor();
		t_divider();
		complete_run();
	end

	// Watchdog
	initial begin
		#100us;
		miscompares++;
		complete_run();
	end
endmodule
